// ### design/vrf_pkg.sv
// Package: register map, field layout and types of the regulator register file
package vrf_pkg;

  localparam int VRF_NUM_REG = 2;

  // --------------------------------------------------------------------------
  // Register indices
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_VENDOR_IDENTIFIER = 8'h00;
  localparam logic [7:0] IDX_PRODUCT_IDENTIFIER = 8'h01;
  localparam logic [7:0] IDX_PRODUCT_REVISION = 8'h02;
  localparam logic [7:0] IDX_PROTOCOL_VERSION = 8'h05;
  localparam logic [7:0] IDX_CAPABILITY_FLAGS = 8'h06;
  localparam logic [7:0] IDX_PRIMARY_STATUS = 8'h10;
  localparam logic [7:0] IDX_BUS_ERROR_STATUS = 8'h11;
  localparam logic [7:0] IDX_TEMPERATURE_ZONE = 8'h12;
  localparam logic [7:0] IDX_ERROR_STATUS_LAST_READ = 8'h1c;
  localparam logic [7:0] IDX_MAX_CURRENT_CAPABILITY = 8'h21;
  localparam logic [7:0] IDX_MAX_TEMPERATURE = 8'h22;
  localparam logic [7:0] IDX_FAST_SLEW_CAPABILITY = 8'h24;
  localparam logic [7:0] IDX_SLOW_SLEW_CAPABILITY = 8'h25;
  localparam logic [7:0] IDX_BOOT_VOLTAGE_CODE = 8'h26;
  localparam logic [7:0] IDX_MAX_VOLTAGE_LIMIT = 8'h30;
  localparam logic [7:0] IDX_VOLTAGE_CODE_SETTING = 8'h31;
  localparam logic [7:0] IDX_POWER_STATE_SETTING = 8'h32;
  localparam logic [7:0] IDX_VOLTAGE_MARGIN_OFFSET = 8'h33;
  localparam logic [7:0] IDX_MULTI_REGULATOR_CONFIG = 8'h34;
  localparam logic [7:0] IDX_REGISTER_POINTER_SCRATCH = 8'h35;

  // --------------------------------------------------------------------------
  // Reset and hard-coded values
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_PROTOCOL_VERSION = 8'h01;
  localparam logic [7:0] RST_CAPABILITY_FLAGS = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MAX_TEMPERATURE = 8'h64;
  localparam logic [7:0] RST_MAX_VOLTAGE_LIMIT = 8'hfb;
  localparam logic [7:0] SLEW_FAST_LOW = 8'h0a;
  localparam logic [7:0] SLEW_FAST_HIGH = 8'h14;
  localparam logic [7:0] SLEW_SLOW_LOW = 8'h02;
  localparam logic [7:0] SLEW_SLOW_HIGH = 8'h04;
  localparam logic [7:0] BOOT_CODE_STANDARD = 8'h00;
  localparam logic [7:0] BOOT_CODE_SPLIT_B = 8'h83;
  localparam logic [7:0] BOOT_CODE_HIGH = 8'hab;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int ST_SETTLED = 0;
  localparam int ST_THERMAL = 1;
  localparam int ST_OVERCURRENT = 2;
  localparam int ST_ERROR_PENDING = 7;
  localparam int ERR_PARITY = 0;
  localparam int ERR_FRAME = 1;
  localparam int ZONE_ALERT = 6;
  localparam int ZONE_HOT = 7;
  localparam int CFG_LOCK = 1;
  localparam int CFG_WIDTH = 2;
  localparam int ERR_WIDTH = 2;

  // --------------------------------------------------------------------------
  // Acknowledge codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] ACK_OK = 2'b10;
  localparam logic [1:0] ACK_NOT_SUPPORTED = 2'b01;
  localparam logic [1:0] ACK_REJECT = 2'b11;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SET_TARGET_VOLTAGE,
    OP_SET_POWER_STATE,
    OP_SET_REGISTER_POINTER,
    OP_WRITE_REGISTER_DATA,
    OP_READ_REGISTER,
    OP_UNSUPPORTED
  } vrf_op_t;

  typedef enum logic [1:0] {
    VAR_STANDARD,
    VAR_SPLIT_BOOT,
    VAR_HIGH_BOOT
  } vrf_variant_t;

  typedef struct packed {
    vrf_op_t op;
    logic reg_sel;
    logic [7:0] payload;
  } vrf_cmd_t;

  typedef struct packed {
    logic [1:0] ack;
    logic [7:0] data;
  } vrf_rsp_t;

endpackage

// ### design/vrf_register_file.sv
// Dual-regulator serial voltage-ID register file with alert and throttle
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Reset restores every default; enable low restores all but throttle, which only srst clears
// - Two separate register files, one per regulator
// - Status bits live; overcurrent latched, read updates
// - Any status bit change pulls alert low
// - Settled low while slewing, set in window
// - Thermal alert at 97 percent of ceiling
// - Bit 7 flags error change; bits 3-6 zero
// - Error register: parity bit 0, frame bit 1
// - Reading error register copies, then clears it
// - Zone register holds thermometer code from thermistors
// - Zone bit 6 sets thermal alert, alert low
// - Zone bit 7 on either pulls throttle low
// - Throttle path independent of registers and bus
// - Temperature ceiling read-only 100 degrees, shared
// - Target commands above limit refused, target kept; data writes to 0x31 not checked
// - Signed offset added to programmed voltage code
// - Slew capability from strap; slow is one fifth
// - Current capability from strap, read-only
// - Boot voltage code depends on part variant
// - Pointer payload stored, targets later data writes
// - Identity registers constant; date, lot unsupported
// - Unsupported index on pointer or read rejected
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module vrf_register_file
  import vrf_pkg::*;
#(
  parameter vrf_variant_t VARIANT = VAR_STANDARD,
  parameter logic [7:0] VENDOR_CODE = 8'h5a,   // Arbitrary value
  parameter logic [7:0] PRODUCT_CODE = 8'h3c,  // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h02  // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic [7:0] thermistor_input_a,
  input wire logic [7:0] thermistor_input_b,
  input wire logic [1:0] output_in_window,
  input wire logic [1:0] overcurrent_in,
  input wire logic [7:0] current_limit_strap_a,
  input wire logic [7:0] current_limit_strap_b,
  input wire logic slew_rate_strap,
  input wire logic cmd_valid,
  input wire vrf_cmd_t cmd,
  input wire logic err_parity_evt,
  input wire logic err_frame_evt,
  input wire logic err_reg_sel,
  output logic rsp_valid_ff,
  output vrf_rsp_t rsp_ff,
  output logic alert_n_ff,
  output logic thermal_throttle_n_ff,
  output logic [1:0][7:0] target_code_ff
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam int SYNC_W = 38;

  logic [SYNC_W-1:0] pin_meta_ff;
  logic [SYNC_W-1:0] pin_sync_ff;
  logic en_s;
  logic [7:0] zone_a_s;
  logic [7:0] zone_b_s;
  logic [1:0] window_s;
  logic [1:0] oc_s;
  logic [7:0] ilim_a_s;
  logic [7:0] ilim_b_s;
  logic slew_s;
  logic clr;

  // No reset: straps must reach the capture flops while reset is held
  always_ff @(posedge ref_clk) begin
    pin_meta_ff <= {enable, thermistor_input_a, thermistor_input_b,
                    output_in_window, overcurrent_in,
                    current_limit_strap_a, current_limit_strap_b,
                    slew_rate_strap};
    pin_sync_ff <= pin_meta_ff;
  end

  assign {en_s, zone_a_s, zone_b_s, window_s, oc_s, ilim_a_s, ilim_b_s,
          slew_s} = pin_sync_ff;

  // Enable low is a hard reset of the whole register file except the throttle output, which only srst clears
  assign clr = srst | ~en_s;

  // --------------------------------------------------------------------------
  // Throttle output
  // --------------------------------------------------------------------------
  // Fed straight from the synchronised comparators so a dead bus or a
  // held register file cannot mask an overheat.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      thermal_throttle_n_ff <= 1'b1;
    end else begin
      thermal_throttle_n_ff <= ~(zone_a_s[ZONE_HOT] | zone_b_s[ZONE_HOT]);
    end
  end

  // --------------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------------
  logic [1:0][7:0] ilim_ff;
  logic slew_fast_ff;

  // Straps are sampled while held in reset and frozen after release
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ilim_ff[0] <= ilim_a_s;
      ilim_ff[1] <= ilim_b_s;
      slew_fast_ff <= slew_s;
    end
  end

  // --------------------------------------------------------------------------
  // Per-regulator register files
  // --------------------------------------------------------------------------
  logic [1:0] hit;
  logic [1:0][1:0] nxt_ack;
  logic [1:0][7:0] nxt_data;
  logic [1:0] status_changed;
  logic [1:0] status_read;
  logic thermal_live;

  assign thermal_live = zone_a_s[ZONE_ALERT] | zone_b_s[ZONE_ALERT];

  for (genvar r = 0; r < VRF_NUM_REG; r++) begin : g_reg
    logic [7:0] max_v_ff;
    logic [7:0] vcode_ff;
    logic [7:0] pstate_ff;
    logic [7:0] offset_ff;
    logic [CFG_WIDTH-1:0] mcfg_ff;
    logic [7:0] ptr_ff;
    logic [ERR_WIDTH-1:0] err_ff;
    logic [ERR_WIDTH-1:0] err_last_ff;
    logic [7:0] zone_ff;
    logic settled_ff;
    logic settle_pend_ff;
    logic therm_ff;
    logic oc_ff;
    logic err_pend_ff;
    logic [7:0] prev_status_ff;
    logic [7:0] status;
    logic [7:0] boot_code;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic [ERR_WIDTH-1:0] err_evt;
    logic accept_target;
    logic accept_power;
    logic accept_write;
    logic err_read;
    logic signed [9:0] sum;

    assign hit[r] = cmd_valid & (cmd.reg_sel == 1'(r));

    assign status = {err_pend_ff, 4'h0, oc_ff, therm_ff, settled_ff};

    always_comb begin
      boot_code = BOOT_CODE_STANDARD;
      if (VARIANT == VAR_HIGH_BOOT) begin
        boot_code = BOOT_CODE_HIGH;
      end else if (VARIANT == VAR_SPLIT_BOOT && r == 1) begin
        boot_code = BOOT_CODE_SPLIT_B;
      end
    end

    // Readback mux; date and lot indices fall to the reject path
    always_comb begin
      rd_ok = 1'b1;
      rd_val = RST_ZERO;
      case (cmd.payload)
        IDX_VENDOR_IDENTIFIER: rd_val = VENDOR_CODE;
        IDX_PRODUCT_IDENTIFIER: rd_val = PRODUCT_CODE;
        IDX_PRODUCT_REVISION: rd_val = REVISION_CODE;
        IDX_PROTOCOL_VERSION: rd_val = RST_PROTOCOL_VERSION;
        IDX_CAPABILITY_FLAGS: rd_val = RST_CAPABILITY_FLAGS;
        IDX_PRIMARY_STATUS: rd_val = status;
        IDX_BUS_ERROR_STATUS: rd_val = {6'h00, err_ff};
        IDX_TEMPERATURE_ZONE: rd_val = zone_ff;
        IDX_ERROR_STATUS_LAST_READ: rd_val = {6'h00, err_last_ff};
        IDX_MAX_CURRENT_CAPABILITY: rd_val = ilim_ff[r];
        IDX_MAX_TEMPERATURE: rd_val = RST_MAX_TEMPERATURE;
        IDX_FAST_SLEW_CAPABILITY: begin
          rd_val = slew_fast_ff ? SLEW_FAST_HIGH : SLEW_FAST_LOW;
        end
        IDX_SLOW_SLEW_CAPABILITY: begin
          rd_val = slew_fast_ff ? SLEW_SLOW_HIGH : SLEW_SLOW_LOW;
        end
        IDX_BOOT_VOLTAGE_CODE: rd_val = boot_code;
        IDX_MAX_VOLTAGE_LIMIT: rd_val = max_v_ff;
        IDX_VOLTAGE_CODE_SETTING: rd_val = vcode_ff;
        IDX_POWER_STATE_SETTING: rd_val = pstate_ff;
        IDX_VOLTAGE_MARGIN_OFFSET: rd_val = offset_ff;
        IDX_MULTI_REGULATOR_CONFIG: rd_val = {6'h00, mcfg_ff};
        IDX_REGISTER_POINTER_SCRATCH: rd_val = ptr_ff;
        default: rd_ok = 1'b0;
      endcase
    end

    // Only the master-programmed block accepts data writes
    assign wr_ok = (ptr_ff >= IDX_MAX_VOLTAGE_LIMIT) &&
                   (ptr_ff <= IDX_REGISTER_POINTER_SCRATCH);

    always_comb begin
      nxt_ack[r] = ACK_REJECT;
      nxt_data[r] = RST_ZERO;
      case (cmd.op)
        OP_SET_TARGET_VOLTAGE: begin
          if (mcfg_ff[CFG_LOCK]) begin
            nxt_ack[r] = ACK_REJECT;
          end else if (cmd.payload > max_v_ff) begin
            nxt_ack[r] = ACK_NOT_SUPPORTED;
          end else begin
            nxt_ack[r] = ACK_OK;
          end
        end
        OP_SET_POWER_STATE: begin
          // Not taken mid-slew or while locked
          if (!mcfg_ff[CFG_LOCK] && !settle_pend_ff) begin
            nxt_ack[r] = ACK_OK;
          end
        end
        OP_SET_REGISTER_POINTER: begin
          nxt_ack[r] = rd_ok ? ACK_OK : ACK_REJECT;
        end
        OP_WRITE_REGISTER_DATA: begin
          nxt_ack[r] = wr_ok ? ACK_OK : ACK_REJECT;
        end
        OP_READ_REGISTER: begin
          nxt_ack[r] = rd_ok ? ACK_OK : ACK_REJECT;
          nxt_data[r] = rd_val;
        end
        default: nxt_ack[r] = ACK_REJECT;
      endcase
    end

    assign accept_target = hit[r] && cmd.op == OP_SET_TARGET_VOLTAGE &&
                           nxt_ack[r] == ACK_OK;
    assign accept_power = hit[r] && cmd.op == OP_SET_POWER_STATE &&
                          nxt_ack[r] == ACK_OK;
    assign accept_write = hit[r] && cmd.op == OP_WRITE_REGISTER_DATA &&
                          wr_ok;
    assign status_read[r] = hit[r] && cmd.op == OP_READ_REGISTER &&
                            cmd.payload == IDX_PRIMARY_STATUS;
    assign err_read = hit[r] && cmd.op == OP_READ_REGISTER &&
                      cmd.payload == IDX_BUS_ERROR_STATUS;
    assign err_evt = (err_reg_sel == 1'(r)) ?
                     {err_frame_evt, err_parity_evt} : '0;

    // Master-written registers
    always_ff @(posedge ref_clk) begin
      if (clr) begin
        max_v_ff <= RST_MAX_VOLTAGE_LIMIT;
        vcode_ff <= RST_ZERO;
        pstate_ff <= RST_ZERO;
        offset_ff <= RST_ZERO;
        mcfg_ff <= '0;
        ptr_ff <= RST_ZERO;
      end else begin
        if (hit[r] && cmd.op == OP_SET_REGISTER_POINTER && rd_ok) begin
          ptr_ff <= cmd.payload;
        end
        if (accept_target) begin
          vcode_ff <= cmd.payload;
          pstate_ff <= RST_ZERO;
        end else if (accept_power) begin
          pstate_ff <= cmd.payload;
        end
        if (accept_write) begin
          case (ptr_ff)
            IDX_MAX_VOLTAGE_LIMIT: max_v_ff <= cmd.payload;
            IDX_VOLTAGE_CODE_SETTING: vcode_ff <= cmd.payload;
            IDX_POWER_STATE_SETTING: pstate_ff <= cmd.payload;
            IDX_VOLTAGE_MARGIN_OFFSET: offset_ff <= cmd.payload;
            IDX_MULTI_REGULATOR_CONFIG: mcfg_ff <= cmd.payload[CFG_WIDTH-1:0];
            IDX_REGISTER_POINTER_SCRATCH: ptr_ff <= cmd.payload;
            default: ptr_ff <= ptr_ff;
          endcase
        end
      end
    end

    // Error recording; a new event in the read cycle survives the clear
    always_ff @(posedge ref_clk) begin
      if (clr) begin
        err_ff <= '0;
        err_last_ff <= '0;
        err_pend_ff <= 1'b0;
      end else begin
        if (err_read) begin
          err_last_ff <= err_ff;
          err_ff <= err_evt;
        end else begin
          err_ff <= err_ff | err_evt;
        end
        if (|err_evt) begin
          err_pend_ff <= 1'b1;
        end else if (err_read) begin
          err_pend_ff <= 1'b0;
        end
      end
    end

    // Live status bits
    always_ff @(posedge ref_clk) begin
      if (clr) begin
        zone_ff <= RST_ZERO;
        therm_ff <= 1'b0;
        oc_ff <= 1'b0;
      end else begin
        zone_ff <= (r == 0) ? zone_a_s : zone_b_s;
        therm_ff <= thermal_live;
        oc_ff <= oc_s[r] | (oc_ff & ~status_read[r]);
      end
    end

    // Settled tracking; a fresh target drops the bit until in window
    always_ff @(posedge ref_clk) begin
      if (clr) begin
        settled_ff <= 1'b0;
        settle_pend_ff <= 1'b0;
      end else if (accept_target) begin
        settled_ff <= 1'b0;
        settle_pend_ff <= 1'b1;
      end else if (settle_pend_ff && window_s[r]) begin
        settled_ff <= 1'b1;
        settle_pend_ff <= 1'b0;
      end
    end

    // Effective target with signed offset, clamped to the code range
    assign sum = $signed({2'b00, vcode_ff}) +
                 $signed({{2{offset_ff[7]}}, offset_ff});

    always_ff @(posedge ref_clk) begin
      if (clr) begin
        target_code_ff[r] <= RST_ZERO;
        prev_status_ff <= RST_ZERO;
      end else begin
        if (sum < 0) begin
          target_code_ff[r] <= RST_ZERO;
        end else if (sum > 10'sd255) begin
          target_code_ff[r] <= 8'hff;
        end else begin
          target_code_ff[r] <= sum[7:0];
        end
        prev_status_ff <= status;
      end
    end

    assign status_changed[r] = status != prev_status_ff;
  end

  // --------------------------------------------------------------------------
  // Response and alert
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= cmd_valid;
      if (cmd_valid) begin
        rsp_ff.ack <= nxt_ack[cmd.reg_sel];
        rsp_ff.data <= nxt_data[cmd.reg_sel];
      end
    end
  end

  // A change in the same cycle as a status read keeps alert asserted
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      alert_n_ff <= 1'b1;
    end else if (|status_changed) begin
      alert_n_ff <= 1'b0;
    end else if (|status_read) begin
      alert_n_ff <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ### verif/vrf_register_file_asserts.sv
// Checker: port-level properties of the regulator register file
`timescale 1ns/10ps
`default_nettype none
module vrf_register_file_asserts
  import vrf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic [7:0] thermistor_input_a,
  input wire logic [7:0] thermistor_input_b,
  input wire logic cmd_valid,
  input wire vrf_cmd_t cmd,
  input wire logic err_parity_evt,
  input wire logic rsp_valid_ff,
  input wire vrf_rsp_t rsp_ff,
  input wire logic alert_n_ff,
  input wire logic thermal_throttle_n_ff,
  input wire logic [1:0][7:0] target_code_ff
);
  logic rd_req;
  logic hot_in;
  assign rd_req = cmd_valid && cmd.op == OP_READ_REGISTER;
  assign hot_in = thermistor_input_a[7] || thermistor_input_b[7];
  // Enable low resets the file late through a synchroniser
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !enable);

  a_read_unused: assert property (
    rd_req && cmd.payload inside {[8'h07:8'h0e]}
    |=> rsp_valid_ff && rsp_ff.ack == ACK_REJECT)
    else $error("unused index read not rejected");
  a_pointer_outside: assert property (
    cmd_valid && cmd.op == OP_SET_REGISTER_POINTER &&
    cmd.payload inside {[8'h36:8'h6f]}
    |=> rsp_valid_ff && rsp_ff.ack == ACK_REJECT)
    else $error("unused pointer not rejected");
  a_ceiling_fixed: assert property (
    rd_req && cmd.payload == IDX_MAX_TEMPERATURE
    |=> rsp_ff.data == RST_MAX_TEMPERATURE && rsp_ff.ack == ACK_OK)
    else $error("temperature ceiling read wrong");
  a_protocol_const: assert property (
    rd_req && cmd.payload == IDX_PROTOCOL_VERSION
    |=> rsp_ff.data == RST_PROTOCOL_VERSION)
    else $error("protocol version read wrong");
  a_error_alert: assert property (
    err_parity_evt && alert_n_ff |-> ##[1:3] !alert_n_ff)
    else $error("alert missing after error event");
  a_alert_holds: assert property (
    !alert_n_ff && !(rd_req && cmd.payload == IDX_PRIMARY_STATUS)
    |=> !alert_n_ff)
    else $error("alert released without status read");
  a_throttle_hot: assert property (
    @(posedge ref_clk) disable iff (srst)
    hot_in [*4] |=> !thermal_throttle_n_ff)
    else $error("throttle not asserted when hot");
  a_throttle_cool: assert property (
    @(posedge ref_clk) disable iff (srst)
    !hot_in [*4] |=> thermal_throttle_n_ff)
    else $error("throttle asserted while cool");
  a_regs_separate: assert property (
    cmd_valid && !cmd.reg_sel |=> $stable(target_code_ff[1]) [*3])
    else $error("command to one regulator moved the other");

  c_reject: cover property (cmd_valid ##1 rsp_ff.ack == ACK_REJECT);
  c_throttle: cover property ($fell(thermal_throttle_n_ff));
  c_alert: cover property ($fell(alert_n_ff));
endmodule
`default_nettype wire

// ### verif/vrf_cpu_master.sv
// Partner model: serial bus master issuing commands to the register file
`timescale 1ns/10ps
`default_nettype none
module vrf_cpu_master
  import vrf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rsp_valid_ff,
  input wire vrf_rsp_t rsp_ff,
  output var logic cmd_valid,
  output var vrf_cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '{OP_UNSUPPORTED, 1'b0, 8'h00};
  end

  // Answer stands one cycle, so it is taken right after that edge
  task automatic xfer(input vrf_op_t op, input logic sel,
                      input logic [7:0] pl, output vrf_rsp_t rsp);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{op, sel, pl};
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    // Idle payload inverted so stale data never looks valid
    cmd.payload = ~pl;
    rsp = '0;
    if (rsp_valid_ff) begin
      rsp = rsp_ff;
    end
  endtask

  // Limit goes in before any voltage request
  task automatic boot_limit(input logic sel, input logic [7:0] lim,
                            output vrf_rsp_t rsp);
    vrf_rsp_t ptr_rsp;
    xfer(OP_SET_REGISTER_POINTER, sel, IDX_MAX_VOLTAGE_LIMIT,
         ptr_rsp);
    xfer(OP_WRITE_REGISTER_DATA, sel, lim, rsp);
    if (ptr_rsp.ack != ACK_OK) begin
      rsp.ack = ptr_rsp.ack;
    end
  endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Testbench: register map, alert, throttle and command sequences
`timescale 1ns/10ps
`default_nettype none
bind vrf_register_file vrf_register_file_asserts
  vrf_register_file_asserts_inst (
  .ref_clk, .srst, .enable, .thermistor_input_a, .thermistor_input_b,
  .cmd_valid, .cmd, .err_parity_evt, .rsp_valid_ff, .rsp_ff,
  .alert_n_ff, .thermal_throttle_n_ff, .target_code_ff);

module tb
  import vrf_pkg::*;
;
  localparam logic [7:0] IDX_TAB [20] = '{8'h00, 8'h01, 8'h02, 8'h05,
    8'h06, 8'h10, 8'h11, 8'h12, 8'h1c, 8'h21, 8'h22, 8'h24, 8'h25,
    8'h26, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
  // Identity values arbitrary; strap slot replaced per regulator
  localparam logic [7:0] EXP_TAB [20] = '{8'h4e, 8'h2d, 8'h03, 8'h01,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h0a, 8'h02,
    8'h00, 8'hfb, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] STRAP [2] = '{8'h23, 8'h16};
  logic ref_clk;
  logic srst = 1'b1;
  logic enable = 1'b1;
  logic [7:0] thermistor_input_a = 8'h00;
  logic [7:0] thermistor_input_b = 8'h00;
  logic [1:0] output_in_window = 2'h0;
  logic [1:0] overcurrent_in = 2'h0;
  logic err_parity_evt = 1'b0;
  logic err_frame_evt = 1'b0;
  logic err_reg_sel = 1'b0;
  logic slew_rate_strap = 1'b0;
  logic cmd_valid;
  vrf_cmd_t cmd;
  logic rsp_valid_ff;
  vrf_rsp_t rsp_ff;
  logic alert_n_ff;
  logic thermal_throttle_n_ff;
  logic [1:0][7:0] target_code_ff;
  vrf_rsp_t lim_rsp;
  int fails = 0;
  int compares = 0;

  vrf_register_file #(
    .VENDOR_CODE(8'h4e),
    .PRODUCT_CODE(8'h2d),
    .REVISION_CODE(8'h03)
  ) vrf_register_file_inst (
    .ref_clk, .srst, .enable, .thermistor_input_a, .thermistor_input_b,
    .output_in_window, .overcurrent_in,
    .current_limit_strap_a(STRAP[0]), .current_limit_strap_b(STRAP[1]),
    .slew_rate_strap, .cmd_valid, .cmd, .err_parity_evt,
    .err_frame_evt, .err_reg_sel, .rsp_valid_ff, .rsp_ff, .alert_n_ff,
    .thermal_throttle_n_ff, .target_code_ff);

  vrf_cpu_master vrf_cpu_master_inst (
    .ref_clk, .rsp_valid_ff, .rsp_ff, .cmd_valid, .cmd);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic op(input vrf_op_t o, input logic s,
                    input logic [7:0] pl, input logic [1:0] ack);
    vrf_rsp_t r;
    vrf_cpu_master_inst.xfer(o, s, pl, r);
    chk($sformatf("ack op %0d arg %h", o, pl), {6'h00, ack},
        {6'h00, r.ack});
  endtask

  task automatic rd(input logic s, input logic [7:0] idx,
                    input logic [7:0] exp);
    vrf_rsp_t r;
    vrf_cpu_master_inst.xfer(OP_READ_REGISTER, s, idx, r);
    chk($sformatf("read ack %h", idx), {6'h00, ACK_OK}, {6'h00, r.ack});
    chk($sformatf("reg %0d.%h", s, idx), exp, r.data);
  endtask

  task automatic wr(input logic s, input logic [7:0] idx,
                    input logic [7:0] d, input logic [1:0] ack);
    op(OP_SET_REGISTER_POINTER, s, idx, ACK_OK);
    op(OP_WRITE_REGISTER_DATA, s, d, ack);
  endtask

  task automatic pulse_err(input logic parity, input logic s);
    err_parity_evt = parity;
    err_frame_evt = !parity;
    err_reg_sel = s;
    cyc(1);
    err_parity_evt = 1'b0;
    err_frame_evt = 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  initial begin
    logic [7:0] e;
    cyc(10);
    srst = 1'b0;
    cyc(4);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 20; i++) begin
        e = (IDX_TAB[i] == 8'h21) ? STRAP[s] : EXP_TAB[i];
        rd(s[0], IDX_TAB[i], e);
      end
    end
    op(OP_READ_REGISTER, 1'b0, 8'h03, ACK_REJECT);
    op(OP_READ_REGISTER, 1'b1, 8'h07, ACK_REJECT);
    op(OP_SET_REGISTER_POINTER, 1'b0, 8'h36, ACK_REJECT);
    vrf_cpu_master_inst.boot_limit(1'b0, 8'h80, lim_rsp);
    chk("limit ack", {6'h00, ACK_OK}, {6'h00, lim_rsp.ack});
    wr(1'b0, 8'h33, 8'h03, ACK_OK);
    rd(1'b1, 8'h33, 8'h00);
    op(OP_SET_TARGET_VOLTAGE, 1'b0, 8'h81, ACK_NOT_SUPPORTED);
    rd(1'b0, 8'h31, 8'h00);
    op(OP_SET_TARGET_VOLTAGE, 1'b0, 8'h40, ACK_OK);
    op(OP_SET_POWER_STATE, 1'b0, 8'h01, ACK_REJECT);
    cyc(2);
    chk("target a", 8'h43, target_code_ff[0]);
    op(OP_WRITE_REGISTER_DATA, 1'b0, 8'hfe, ACK_OK);
    cyc(3);
    chk("target a", 8'h3e, target_code_ff[0]);
    chk("target b", 8'h00, target_code_ff[1]);
    wr(1'b1, 8'h33, 8'h05, ACK_OK);
    cyc(2);
    chk("target b", 8'h05, target_code_ff[1]);
    rd(1'b0, 8'h10, 8'h00);
    output_in_window = 2'h1;
    cyc(5);
    chk("alert", 8'h00, {7'h00, alert_n_ff});
    rd(1'b0, 8'h10, 8'h01);
    chk("alert", 8'h01, {7'h00, alert_n_ff});
    op(OP_SET_POWER_STATE, 1'b0, 8'h01, ACK_OK);
    rd(1'b0, 8'h32, 8'h01);
    pulse_err(1'b1, 1'b0);
    cyc(3);
    rd(1'b0, 8'h10, 8'h81);
    rd(1'b0, 8'h11, 8'h01);
    rd(1'b0, 8'h1c, 8'h01);
    rd(1'b0, 8'h11, 8'h00);
    rd(1'b0, 8'h10, 8'h01);
    overcurrent_in = 2'h2;
    cyc(5);
    overcurrent_in = 2'h0;
    cyc(5);
    rd(1'b1, 8'h10, 8'h04);
    rd(1'b1, 8'h10, 8'h00);
    pulse_err(1'b0, 1'b1);
    cyc(3);
    rd(1'b1, 8'h11, 8'h02);
    thermistor_input_a = 8'h7f;
    cyc(5);
    rd(1'b0, 8'h12, 8'h7f);
    rd(1'b1, 8'h10, 8'h02);
    rd(1'b0, 8'h10, 8'h03);
    chk("throttle", 8'h01, {7'h00, thermal_throttle_n_ff});
    thermistor_input_b = 8'hff;
    cyc(5);
    chk("throttle", 8'h00, {7'h00, thermal_throttle_n_ff});
    rd(1'b1, 8'h12, 8'hff);
    wr(1'b0, 8'h22, 8'h00, ACK_REJECT);
    rd(1'b0, 8'h22, 8'h64);
    wr(1'b0, 8'h34, 8'h02, ACK_OK);
    op(OP_SET_TARGET_VOLTAGE, 1'b0, 8'h10, ACK_REJECT);
    chk("target a", 8'h3e, target_code_ff[0]);
    enable = 1'b0;
    slew_rate_strap = 1'b1;
    cyc(5);
    chk("throttle", 8'h00, {7'h00, thermal_throttle_n_ff});
    enable = 1'b1;
    cyc(5);
    rd(1'b0, 8'h33, 8'h00);
    rd(1'b0, 8'h30, 8'hfb);
    rd(1'b0, 8'h34, 8'h00);
    rd(1'b0, 8'h24, SLEW_FAST_HIGH);
    rd(1'b1, 8'h25, SLEW_SLOW_HIGH);
    stop_test();
  end
endmodule
`default_nettype wire
